// File: src/tcc_pkg.sv
// Shared constants and types of the terminal character controller
package tcc_pkg;
    // Register indices; the byte address is four times the index
    localparam logic [11:0] TCC_IDX_DATA = 12'h090;
    localparam logic [11:0] TCC_IDX_FUNC = 12'h091;
    localparam logic [31:0] TCC_ADR_DATA = {18'h00000, TCC_IDX_DATA, 2'h0};
    localparam logic [31:0] TCC_ADR_FUNC = {18'h00000, TCC_IDX_FUNC, 2'h0};
    // Director function bit positions
    localparam int TCC_F_CLEAR_CTL = 0;
    localparam int TCC_F_CLEAR_INT = 1;
    localparam int TCC_F_REQ_DATA = 2;
    localparam int TCC_F_REQ_DONE = 3;
    localparam int TCC_F_REQ_ALARM = 4;
    localparam int TCC_F_WRITE_MODE = 8;
    localparam int TCC_F_READ_MODE = 9;
    localparam int TCC_F_RECONNECT = 10;
    localparam int TCC_F_DISCONNECT = 13;
    // Director status bit positions
    localparam int TCC_S_ONE = 0;
    localparam int TCC_S_BUSY = 1;
    localparam int TCC_S_INT = 2;
    localparam int TCC_S_DATA = 3;
    localparam int TCC_S_DONE = 4;
    localparam int TCC_S_ALARM = 5;
    localparam int TCC_S_LOST = 6;
    localparam int TCC_S_PARITY = 7;
    localparam int TCC_S_READ = 9;
    localparam int TCC_S_ONE_HI = 10;
    localparam int TCC_S_MANUAL = 11;
    // Widths
    localparam int TCC_CHAR_W = 8;
    localparam int TCC_WORD_W = 16;
    // Bus slave states
    typedef enum logic [1:0] {
        TCC_IDLE = 2'b01,
        TCC_ANSWER = 2'b10
    } tcc_bus_state_type;
    // Even parity check over a whole character, parity position included
    function automatic logic tcc_parity_ok(input logic [7:0] ch);
        tcc_parity_ok = ~(^ch);
    endfunction
endpackage

// File: src/tcc_cmd_if.sv
// Request and answer carrier between the bus slave and the controller core
`timescale 1ns/1ps
`default_nettype none
interface tcc_cmd_if;
    import tcc_pkg::*;
    logic req; // Instruction presented this cycle
    logic we; // Output from accumulator when high, input when low
    logic func; // Director address when high, data address when low
    logic [TCC_WORD_W-1:0] wdata; // Accumulator word sent
    logic accept; // Core takes the instruction
    logic [TCC_WORD_W-1:0] rdata; // Word returned to the accumulator
    modport slave (output req, output we, output func, output wdata,
                   input accept, input rdata);
    modport core (input req, input we, input func, input wdata,
                  output accept, output rdata);
endinterface
`default_nettype wire

// File: src/tcc_wb_slave.sv
// Classic Wishbone slave that turns bus cycles into controller instructions
`timescale 1ns/1ps
`default_nettype none
module tcc_wb_slave
    import tcc_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    tcc_cmd_if.slave cmd
);
    typedef struct packed {
        tcc_bus_state_type state;
        logic ack;
        logic err;
        logic [31:0] dat;
    } tcc_wb_type;
    tcc_wb_type r; // Registered state
    tcc_wb_type next_r; // Next state
    logic hit; // Address names one of the two words

    // Decode and answer one request per bus cycle
    always_comb begin
        next_r = r;
        hit = (wb_adr_i == TCC_ADR_DATA) || (wb_adr_i == TCC_ADR_FUNC);
        cmd.req = 1'b0;
        cmd.we = wb_we_i;
        cmd.func = (wb_adr_i == TCC_ADR_FUNC);
        cmd.wdata = wb_dat_i[15:0] & {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
        case (r.state)
            TCC_IDLE: begin
                next_r.ack = 1'b0;
                next_r.err = 1'b0;
                if (wb_cyc_i && wb_stb_i) begin
                    // Rejected or unmapped requests end with err
                    cmd.req = hit;
                    next_r.state = TCC_ANSWER;
                    next_r.ack = hit && cmd.accept;
                    next_r.err = !(hit && cmd.accept);
                    next_r.dat = {16'h0000, cmd.rdata};
                end
            end
            TCC_ANSWER: begin
                // Answer stands one cycle, then drops
                next_r.state = TCC_IDLE;
                next_r.ack = 1'b0;
                next_r.err = 1'b0;
            end
            default: begin
                next_r.state = TCC_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            r <= '{state: TCC_IDLE, ack: 1'b0, err: 1'b0, dat: 32'h00000000};
        end else begin
            r <= next_r;
        end
    end

    assign wb_ack_o = r.ack;
    assign wb_err_o = r.err;
    assign wb_dat_o = r.dat;
endmodule
`default_nettype wire

// File: src/tcc_irq.sv
// Level-one interrupt combiner of the terminal character controller
`timescale 1ns/1ps
`default_nettype none
module tcc_irq
    import tcc_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic req_data,
    input wire logic req_done,
    input wire logic req_alarm,
    input wire logic data_status,
    input wire logic busy,
    input wire logic alarm,
    input wire logic manual,
    output logic irq_level1
);
    typedef struct packed {
        logic irq;
    } tcc_irq_type;
    tcc_irq_type r; // Registered state
    tcc_irq_type next_r; // Next state

    // Any of the four conditions holds the line
    always_comb begin
        next_r.irq = (req_data && data_status)
            || (req_done && !busy)
            || (alarm && req_alarm)
            || manual;
    end

    // Line register; level one corresponds to mask bit 01
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            r <= '{irq: 1'b0};
        end else begin
            r <= next_r;
        end
    end

    assign irq_level1 = r.irq;

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    property p_data_irq;
        req_data && data_status |=> irq_level1;
    endproperty
    a_data_irq: assert property (p_data_irq) else $error("data interrupt missing");
    property p_done_irq;
        req_done && !busy |=> irq_level1;
    endproperty
    a_done_irq: assert property (p_done_irq) else $error("done interrupt missing");
    property p_alarm_irq;
        alarm && req_alarm |=> irq_level1;
    endproperty
    a_alarm_irq: assert property (p_alarm_irq) else $error("alarm interrupt missing");
    property p_manual_irq;
        manual |=> irq_level1;
    endproperty
    a_manual_irq: assert property (p_manual_irq) else $error("manual interrupt missing");
    property p_irq_drops;
        !(req_data && data_status) && !(req_done && !busy) && !(alarm && req_alarm)
            && !manual |=> !irq_level1;
    endproperty
    a_irq_drops: assert property (p_irq_drops) else $error("interrupt without cause");
endmodule
`default_nettype wire

// File: src/terminal_char_controller.sv
// Terminal character controller core with Wishbone access and terminal port
// Functional notes
// - Status read always accepted, never rejected
// - Data read places character in low byte
// - Data read changes only the low byte; the word returned here has its upper byte zero
// - Data read needs a held character
// - Clear controller selects read; else mode function
// - Completed data read clears data status
// - Data write only in write mode, not busy
// - Interrupt selections persist until cleared
// - Interrupt goes out on level one
// - Data request with data status interrupts
// - Done request while not busy interrupts
// - Alarm status with alarm request interrupts
// - Manual interrupt status always interrupts
// - No program protection check on commands
// - Characters are eight bits, even parity
// - Data at 0090, director at 0091
// - Clear controller resets requests, states, mode, printer
// - Function bits 2,3,4 select interrupt requests
// - Data status follows mode-specific readiness
//
// The register addresses and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module terminal_char_controller
    import tcc_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    input wire logic rx_valid,
    input wire logic [7:0] rx_char,
    output logic rx_ready,
    output logic tx_valid,
    output logic [7:0] tx_char,
    input wire logic tx_ready,
    input wire logic manual_pulse,
    output logic echo_enable,
    output logic irq_level1
);
    typedef struct packed {
        logic write_mode; // Output operation selected
        logic hold_full; // Hold register has a character for the computer
        logic [7:0] hold; // Received character
        logic tx_pending; // Character waiting to go to the terminal
        logic [7:0] tx_char; // Character being sent
        logic lost; // Lost data alarm
        logic parity_err; // Parity alarm
        logic manual; // Manual interrupt status
        logic req_data; // Data interrupt request
        logic req_done; // Operation done interrupt request
        logic req_alarm; // Alarm interrupt request
        logic printer_on; // Echo to printer or display
    } tcc_ctl_type;
    tcc_ctl_type r; // Registered state
    tcc_ctl_type next_r; // Next state

    tcc_cmd_if cmd(); // Instruction carrier from the bus slave

    logic busy; // Busy status
    logic data_status; // Data status
    logic alarm; // Alarm status
    logic irq_now; // Interrupt status bit
    logic data_rd; // Data read presented
    logic data_wr; // Data write presented
    logic func_wr; // Director function presented
    logic mode_sel; // Function asks for a mode change
    logic other_fn; // Function holds a bit always performed
    logic [15:0] status_word; // Director status
    logic [15:0] fn; // Function word

    // Bus slave
    tcc_wb_slave u_wb (
        .clk(clk),
        .reset(reset),
        .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o),
        .wb_err_o(wb_err_o),
        .cmd(cmd.slave)
    );

    // Interrupt combiner
    tcc_irq u_irq (
        .clk(clk),
        .reset(reset),
        .req_data(r.req_data),
        .req_done(r.req_done),
        .req_alarm(r.req_alarm),
        .data_status(data_status),
        .busy(busy),
        .alarm(alarm),
        .manual(r.manual),
        .irq_level1(irq_level1)
    );

    // Derived status
    always_comb begin
        busy = r.write_mode ? r.tx_pending : r.hold_full;
        data_status = r.write_mode ? !r.tx_pending : r.hold_full;
        alarm = r.lost || r.parity_err;
        irq_now = irq_level1;
        status_word = 16'h0000;
        status_word[TCC_S_ONE] = 1'b1;
        status_word[TCC_S_BUSY] = busy;
        status_word[TCC_S_INT] = irq_now;
        status_word[TCC_S_DATA] = data_status;
        status_word[TCC_S_DONE] = !busy;
        status_word[TCC_S_ALARM] = alarm;
        status_word[TCC_S_LOST] = r.lost;
        status_word[TCC_S_PARITY] = r.parity_err;
        status_word[TCC_S_READ] = !r.write_mode;
        status_word[TCC_S_ONE_HI] = 1'b1;
        status_word[TCC_S_MANUAL] = r.manual;
    end

    // Instruction decode and acceptance; no protect input exists at all
    always_comb begin
        fn = cmd.wdata;
        data_rd = cmd.req && !cmd.we && !cmd.func;
        data_wr = cmd.req && cmd.we && !cmd.func;
        func_wr = cmd.req && cmd.we && cmd.func;
        mode_sel = fn[TCC_F_WRITE_MODE] || fn[TCC_F_READ_MODE];
        other_fn = fn[TCC_F_CLEAR_CTL] || fn[TCC_F_CLEAR_INT] || fn[TCC_F_REQ_DATA]
            || fn[TCC_F_REQ_DONE] || fn[TCC_F_REQ_ALARM] || fn[TCC_F_RECONNECT]
            || fn[TCC_F_DISCONNECT];
        cmd.accept = 1'b1;
        cmd.rdata = status_word;
        if (!cmd.func) begin
            // Only the low byte carries a character; the upper byte reads as zero
            cmd.rdata = {8'h00, r.hold};
            if (cmd.we) begin
                cmd.accept = r.write_mode && !r.tx_pending;
            end else begin
                cmd.accept = !r.write_mode && r.hold_full;
            end
        end else if (cmd.we) begin
            // Refused only when nothing in the word can be done
            cmd.accept = other_fn || !mode_sel || !busy;
        end
    end

    // Controller state update
    always_comb begin
        next_r = r;
        // Terminal takes the outgoing character
        if (r.tx_pending && tx_ready) begin
            next_r.tx_pending = 1'b0;
        end
        // Incoming character from keyboard or reader
        if (rx_valid && !r.write_mode) begin
            if (r.hold_full || r.lost) begin
                next_r.lost = 1'b1;
            end else begin
                next_r.hold = rx_char;
                next_r.hold_full = 1'b1;
                next_r.parity_err = r.parity_err || !tcc_parity_ok(rx_char);
            end
        end
        // Data read empties the hold register
        if (data_rd && cmd.accept) begin
            next_r.hold_full = 1'b0;
        end
        // Data write loads the outgoing character
        if (data_wr && cmd.accept) begin
            next_r.tx_char = cmd.wdata[7:0];
            next_r.tx_pending = 1'b1;
        end
        if (func_wr && cmd.accept) begin
            // Clear interrupt
            if (fn[TCC_F_CLEAR_INT]) begin
                next_r.req_data = 1'b0;
                next_r.req_done = 1'b0;
                next_r.req_alarm = 1'b0;
                next_r.manual = 1'b0;
            end
            // Clear controller
            if (fn[TCC_F_CLEAR_CTL]) begin
                next_r.req_data = 1'b0;
                next_r.req_done = 1'b0;
                next_r.req_alarm = 1'b0;
                next_r.manual = 1'b0;
                next_r.hold_full = 1'b0;
                next_r.tx_pending = 1'b0;
                next_r.lost = 1'b0;
                next_r.parity_err = 1'b0;
                next_r.write_mode = 1'b0;
                next_r.printer_on = 1'b1;
            end else if (!busy) begin
                // Mode change only when idle
                if (fn[TCC_F_WRITE_MODE]) begin
                    next_r.write_mode = 1'b1;
                    // A character lost at this very edge still counts
                    next_r.lost = rx_valid && !r.write_mode && r.lost;
                end else if (fn[TCC_F_READ_MODE]) begin
                    next_r.write_mode = 1'b0;
                end
            end
            // Selections win over the clears in the same word
            if (fn[TCC_F_REQ_DATA]) begin
                next_r.req_data = 1'b1;
            end
            if (fn[TCC_F_REQ_DONE]) begin
                next_r.req_done = 1'b1;
            end
            if (fn[TCC_F_REQ_ALARM]) begin
                next_r.req_alarm = 1'b1;
            end
            // Echo control
            if (fn[TCC_F_DISCONNECT]) begin
                next_r.printer_on = 1'b0;
            end
            if (fn[TCC_F_RECONNECT]) begin
                next_r.printer_on = 1'b1;
            end
        end
        // Manual interrupt wins over a clear in the same cycle
        if (manual_pulse) begin
            next_r.manual = 1'b1;
        end
    end

    // State register
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            r <= '{write_mode: 1'b0, hold_full: 1'b0, hold: 8'h00, tx_pending: 1'b0,
                   tx_char: 8'h00, lost: 1'b0, parity_err: 1'b0, manual: 1'b0,
                   req_data: 1'b0, req_done: 1'b0, req_alarm: 1'b0, printer_on: 1'b1};
        end else begin
            r <= next_r;
        end
    end

    // Terminal side; keyboard locked out after lost data
    assign rx_ready = !r.write_mode && !r.hold_full && !r.lost;
    assign tx_valid = r.tx_pending;
    assign tx_char = r.tx_char;
    assign echo_enable = r.printer_on;

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence s_data_read;
        data_rd && cmd.accept;
    endsequence
    sequence s_data_write;
        data_wr && cmd.accept;
    endsequence

    property p_status_read;
        cmd.req && !cmd.we && cmd.func |-> cmd.accept && cmd.rdata == status_word;
    endproperty
    a_status_read: assert property (p_status_read) else $error("status read refused");
    property p_read_char;
        s_data_read |=> wb_dat_o == {24'h000000, $past(r.hold)};
    endproperty
    a_read_char: assert property (p_read_char) else $error("wrong character read");
    property p_read_low;
        s_data_read |=> wb_dat_o[31:8] == 24'h000000;
    endproperty
    a_read_low: assert property (p_read_low) else $error("upper byte driven");
    property p_read_needs_char;
        data_rd && !(r.hold_full && !r.write_mode) |-> !cmd.accept;
    endproperty
    a_read_needs_char: assert property (p_read_needs_char) else $error("empty read taken");
    property p_clear_mode;
        func_wr && fn[TCC_F_CLEAR_CTL] |=> !r.write_mode && !r.hold_full && !r.lost;
    endproperty
    a_clear_mode: assert property (p_clear_mode) else $error("clear controller incomplete");
    property p_read_clears;
        s_data_read ##1 !rx_valid[*1] |-> !data_status;
    endproperty
    a_read_clears: assert property (p_read_clears) else $error("data status kept");
    property p_write_loads;
        s_data_write |=> tx_valid && tx_char == $past(cmd.wdata[7:0]);
    endproperty
    a_write_loads: assert property (p_write_loads) else $error("write not loaded");
    property p_req_persist;
        !(func_wr && cmd.accept) |=> $stable(r.req_data) && $stable(r.req_alarm);
    endproperty
    a_req_persist: assert property (p_req_persist) else $error("request changed alone");
    property p_write_refused;
        data_wr && (!r.write_mode || r.tx_pending) |-> !cmd.accept ##1 $stable(tx_char);
    endproperty
    a_write_refused: assert property (p_write_refused) else $error("bad write taken");
endmodule
`default_nettype wire

// File: sim/tcc_terminal_model.sv
// Behavioural terminal on the far side of the character port
`timescale 1ns/1ps
`default_nettype none
module tcc_terminal_model (
    input wire logic clk,
    input wire logic reset,
    input wire logic send_req,
    input wire logic [7:0] send_char,
    input wire logic slow,
    output logic rx_valid,
    output logic [7:0] rx_char,
    input wire logic tx_valid,
    input wire logic [7:0] tx_char,
    output logic tx_ready,
    output logic [7:0] last_tx,
    output logic [7:0] printed // Characters that would show on paper or screen
);
    int stall; // Cycles still to wait before taking a character
    // Take a waiting character once the stall has run out
    assign tx_ready = tx_valid && (stall == 0);
    // One receive pulse per request; an idle line inverts the character lines every cycle
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            rx_valid <= 1'b0;
            rx_char <= 8'h00;
        end else if (send_req) begin
            rx_valid <= 1'b1;
            rx_char <= send_char;
        end else begin
            rx_valid <= 1'b0;
            rx_char <= ~rx_char;
        end
    end
    // Slow terminal holds off for a while before each take
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            stall <= 0;
            last_tx <= 8'h00;
            printed <= 8'h00;
        end else if (!tx_valid) begin
            stall <= slow ? 30 : 0;
        end else if (stall > 0) begin
            stall <= stall - 1;
        end else begin
            last_tx <= tx_char;
            // Only columns two to five reach the printer or display
            if (tx_char[6:4] >= 3'h2 && tx_char[6:4] <= 3'h5) begin
                printed <= printed + 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

// File: sim/terminal_char_controller_test.sv
// Self-checking bench of the terminal character controller
`timescale 1ns/1ps
`default_nettype none
module terminal_char_controller_test;
    import tcc_pkg::*;
    logic clk = 1'b0; // Core clock
    logic reset = 1'b1; // Master clear
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0; // Bus request
    logic [31:0] adr = 32'h0, dat = 32'h0, dat_o; // Bus address and data
    logic ack, err, rx_valid, rx_ready, tx_valid, tx_ready, echo, irq; // Design and terminal outputs
    logic [7:0] rx_char, tx_char, last_tx, printed; // Character lines
    logic manual = 1'b0, send_req = 1'b0, slow = 1'b0; // Stimulus to design and terminal
    logic [7:0] send_char = 8'h00; // Character the terminal is told to send
    logic [31:0] seed = 32'h059e96da; // Xorshift state
    int bad_count = 0; // Mismatches
    int checked = 0; // Comparisons made
    int shown = 0; // Characters expected on paper or screen
    always #2 clk = ~clk;
    terminal_char_controller uut (.clk(clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(dat), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .wb_err_o(err), .rx_valid(rx_valid), .rx_char(rx_char),
        .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_char(tx_char), .tx_ready(tx_ready),
        .manual_pulse(manual), .echo_enable(echo), .irq_level1(irq));
    tcc_terminal_model term (.clk(clk), .reset(reset), .send_req(send_req),
        .send_char(send_char), .slow(slow), .rx_valid(rx_valid), .rx_char(rx_char),
        .tx_valid(tx_valid), .tx_char(tx_char), .tx_ready(tx_ready), .last_tx(last_tx),
        .printed(printed));
    // Next pseudo-random word
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // Character with even parity in the top bit
    function automatic logic [7:0] mkchar(input logic [31:0] r);
        return {^r[6:0], r[6:0]};
    endfunction
    // Expected director status word
    function automatic logic [15:0] exp_stat(input logic b, d, r, al, lo, i);
        logic [15:0] s;
        s = 16'h0;
        s[TCC_S_ONE] = 1'b1;
        s[TCC_S_ONE_HI] = 1'b1;
        s[TCC_S_BUSY] = b;
        s[TCC_S_DONE] = ~b;
        s[TCC_S_DATA] = d;
        s[TCC_S_READ] = r;
        s[TCC_S_ALARM] = al;
        s[TCC_S_LOST] = lo;
        s[TCC_S_INT] = i;
        return s;
    endfunction
    // Print counts and verdict, then stop
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Compare one value
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask
    // One classic bus cycle; checks whether it was taken or refused
    task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d,
                      input logic exp_ack, output logic [31:0] rd);
        int n;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (ack === 1'b1 || err === 1'b1) break;
        end
        if (n == 50) begin
            bad_count++;
            tally_and_finish();
        end
        chk("ack", {31'h0, exp_ack}, {31'h0, ack});
        chk("err", {31'h0, ~exp_ack}, {31'h0, err});
        rd = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    // Read and compare the director status
    task automatic st(input logic b, d, r, al, lo, i);
        logic [31:0] v;
        wb(1'b0, TCC_ADR_FUNC, 32'h0, 1'b1, v);
        chk("status", {16'h0, exp_stat(b, d, r, al, lo, i)}, v);
    endtask
    // Let the terminal send one character
    task automatic send(input logic [7:0] c);
        @(posedge clk);
        send_req <= 1'b1;
        send_char <= c;
        @(posedge clk);
        send_req <= 1'b0;
        idle(4);
    endtask
    task automatic endt(input string name);
        $display("test %s done", name);
    endtask
    // Main sequence
    initial begin
        logic [31:0] v;
        logic [7:0] c;
        int n;
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        st(0, 0, 1, 0, 0, 0);
        chk("echo", 32'h1, {31'h0, echo});
        chk("rx_ready", 32'h1, {31'h0, rx_ready});
        wb(1'b0, TCC_ADR_FUNC + 32'h4, 32'h0, 1'b0, v);
        wb(1'b0, TCC_ADR_DATA, 32'h0, 1'b0, v);
        wb(1'b1, TCC_ADR_DATA, 32'h55, 1'b0, v);
        chk("tx_valid", 32'h0, {31'h0, tx_valid});
        endt("reset_and_refusals");
        for (int i = 0; i < 4; i++) begin
            c = mkchar(rnd());
            send(c);
            chk("rx_ready", 32'h0, {31'h0, rx_ready});
            st(1, 1, 1, 0, 0, 0);
            wb(1'b0, TCC_ADR_DATA, 32'h0, 1'b1, v);
            chk("char", {24'h0, c}, v);
            st(0, 0, 1, 0, 0, 0);
        end
        endt("receive");
        wb(1'b1, TCC_ADR_FUNC, 32'h1 << TCC_F_REQ_DATA, 1'b1, v);
        idle(3);
        chk("irq_quiet", 32'h0, {31'h0, irq});
        send(mkchar(rnd()));
        chk("irq_data", 32'h1, {31'h0, irq});
        wb(1'b0, TCC_ADR_DATA, 32'h0, 1'b1, v);
        idle(3);
        chk("irq_drop", 32'h0, {31'h0, irq});
        @(posedge clk);
        manual <= 1'b1;
        @(posedge clk);
        manual <= 1'b0;
        idle(3);
        chk("irq_manual", 32'h1, {31'h0, irq});
        wb(1'b0, TCC_ADR_FUNC, 32'h0, 1'b1, v);
        chk("manual", {16'h0, exp_stat(0, 0, 1, 0, 0, 1) | (16'h1 << TCC_S_MANUAL)}, v);
        v = (32'h1 << TCC_F_CLEAR_INT) | (32'h1 << TCC_F_DISCONNECT);
        wb(1'b1, TCC_ADR_FUNC, v, 1'b1, v);
        chk("echo_off", 32'h0, {31'h0, echo});
        idle(3);
        chk("irq_cleared", 32'h0, {31'h0, irq});
        send(mkchar(rnd()) ^ 8'h80);
        send(mkchar(rnd()));
        wb(1'b1, TCC_ADR_FUNC, 32'h1 << TCC_F_REQ_ALARM, 1'b1, v);
        idle(3);
        chk("irq_alarm", 32'h1, {31'h0, irq});
        wb(1'b0, TCC_ADR_FUNC, 32'h0, 1'b1, v);
        chk("alarm", {16'h0, exp_stat(1, 1, 1, 1, 1, 1) | (16'h1 << TCC_S_PARITY)}, v);
        wb(1'b1, TCC_ADR_FUNC, 32'h1 << TCC_F_CLEAR_CTL, 1'b1, v);
        idle(3);
        chk("irq_clear_ctl", 32'h0, {31'h0, irq});
        chk("echo_on", 32'h1, {31'h0, echo});
        st(0, 0, 1, 0, 0, 0);
        endt("interrupts");
        v = (32'h1 << TCC_F_WRITE_MODE) | (32'h1 << TCC_F_REQ_DONE);
        wb(1'b1, TCC_ADR_FUNC, v, 1'b1, v);
        idle(3);
        st(0, 1, 0, 0, 0, 1);
        for (int i = 0; i < 4; i++) begin
            slow <= i[0];
            c = mkchar(rnd());
            v = rnd();
            wb(1'b1, TCC_ADR_DATA, {v[31:8], c}, 1'b1, v);
            chk("tx_char", {24'h0, c}, {24'h0, tx_char});
            if (i[0]) begin
                wb(1'b1, TCC_ADR_DATA, {24'h0, ~c}, 1'b0, v);
                wb(1'b1, TCC_ADR_FUNC, 32'h1 << TCC_F_READ_MODE, 1'b0, v);
                chk("irq_busy", 32'h0, {31'h0, irq});
                st(1, 0, 0, 0, 0, 0);
            end
            for (n = 0; n < 100 && tx_valid === 1'b1; n++) @(posedge clk);
            if (n == 100) begin
                bad_count++;
                tally_and_finish();
            end
            chk("sent", {24'h0, c}, {24'h0, last_tx});
            shown += (c[6:4] >= 3'h2 && c[6:4] <= 3'h5);
            idle(3);
            st(0, 1, 0, 0, 0, 1);
        end
        chk("printed", shown, {24'h0, printed});
        endt("transmit");
        tally_and_finish();
    end
endmodule
`default_nettype wire
